// File: core/timer_pin_mux_reset_irq_inputs.sv
// Pin function mux, interrupt input conditioning and reset release
// Summary of operation
// RULE1: Pin 0 starts as timer channel 0; may be serial 0 TX or port C bit 6.
// RULE2: Pin 1 starts as timer channel 1; may be serial 0 RX or port C bit 5.
// RULE3: Pin 2 comes up as timer C channel 3; software may pick port C bit 4.
// RULE4: A pin in port mode has its own direction bit set by software.
// RULE5: In stop or wait the interrupt request is taken without the clock; the code skips the synchroniser but still registers IRQ_WAKE on CLK.
// RULE6: In other modes the interrupt request is synchronised to the clock.
// RULE7: Software picks level-sensitive or falling-edge interrupt request.
// RULE8: While the reset pin is low the logic is held in reset.
// RULE9: Internal reset releases on the clock a fixed count after pin rise.
// RULE10: The board drives reset and debug reset together for a full reset.
// RULE11: Reset alone leaves the debug logic running.
// RULE12: The release count is a parameter, after a two-stage synchroniser.
// RULE13: In reset all five pins are inputs with pull-ups on.
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`include "pin_mux_consts.svh"
module timer_pin_mux_reset_irq_inputs #(
    parameter int RST_RELEASE_CYC = `PM_RST_RELEASE_CYC
) (
    // Clock and bus reset
    input wire logic CLK,
    input wire logic SRST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Multiplexed pins, oe low drives
    input wire logic [2:0] MUX_PIN_IN,
    output logic [2:0] MUX_PIN_OUT,
    output logic [2:0] MUX_PIN_OE_N,
    output logic [4:0] PIN_PULLUP_EN,
    // Peripheral side of the pins
    input wire logic TIMER_C_CHANNEL0_OUT,
    input wire logic TIMER_C_CHANNEL1_OUT,
    input wire logic TIMER_C_CHANNEL3_OUT,
    input wire logic [2:0] TIMER_C_DRIVE,
    output logic [2:0] TIMER_C_IN,
    input wire logic SERIAL0_TRANSMIT_OUT,
    output logic SERIAL0_RECEIVE_IN,
    // Interrupt request pin and low power mode
    input wire logic EXTERNAL_INTERRUPT_REQUEST_N,
    input wire logic STOP_OR_WAIT,
    output logic IRQ_SERVICE,
    output logic IRQ_WAKE,
    output logic IRQ,
    // Hardware and debug reset
    input wire logic HW_RESET_N,
    input wire logic DEBUG_RESET_N,
    output logic CORE_RESET,
    output logic DEBUG_RESET
);

    localparam int CW = $clog2(RST_RELEASE_CYC + 1);
    // Whole block state, registered as one word
    typedef struct packed {
        logic [5:0] func;
        logic [2:0] dir;
        logic [2:0] pout;
        logic irq_edge;
        logic [1:0] stat;
        logic [1:0] mask;
        logic [2:0] irq_sync;
        logic irq_prev;
        logic [1:0] rst_sync;
        pin_mux_pkg::rst_state_t rst_st;
        logic [CW-1:0] rst_cnt;
        logic [2:0] pin_s1;
        logic [2:0] pin_s2;
        logic [2:0] pin_s3;
        logic [2:0] pin_val;
        logic [2:0] dbg_sync;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [2:0] mout;
        logic [2:0] moe_n;
        logic [4:0] pull;
        logic [2:0] tin;
        logic rxd;
        logic service;
        logic wake;
        logic irq;
        logic core_rst;
        logic dbg_rst;
    } state_t;
    state_t cur_ff;
    state_t nxt_st;
    logic stat_ev_irq;
    logic stat_ev_rst;
    logic acc;
    logic wr;
    logic [2:0] tmr_v;
    logic [2:0] out_v;
    logic [2:0] drv_v;
    pin_mux_pkg::pin_func_t f [3];

    always_comb begin
        nxt_st = cur_ff;
        acc = PSEL & PENABLE & ~cur_ff.pready;
        wr = acc & PWRITE;

        // Reset pin synchroniser and release counter
        nxt_st.rst_sync = {cur_ff.rst_sync[0], HW_RESET_N}; // [RULE12]
        unique case (cur_ff.rst_st)
            pin_mux_pkg::RST_HOLD: begin
                nxt_st.rst_cnt = '0;
                if (cur_ff.rst_sync[1]) begin
                    nxt_st.rst_st = pin_mux_pkg::RST_COUNT;
                end
            end
            pin_mux_pkg::RST_COUNT: begin
                nxt_st.rst_cnt = cur_ff.rst_cnt + CW'(1);
                if (cur_ff.rst_cnt == CW'(RST_RELEASE_CYC - 1)) begin
                    nxt_st.rst_st = pin_mux_pkg::RST_RUN; // [RULE9]
                end
            end
            pin_mux_pkg::RST_RUN: begin
                nxt_st.rst_cnt = cur_ff.rst_cnt;
            end
            default: begin
                // Corrupted code falls back to holding reset
                nxt_st.rst_st = pin_mux_pkg::RST_HOLD;
            end
        endcase
        // Pin low wins over the counter at any point
        if (!cur_ff.rst_sync[1]) begin
            nxt_st.rst_st = pin_mux_pkg::RST_HOLD; // [RULE8]
        end
        nxt_st.core_rst = (nxt_st.rst_st != pin_mux_pkg::RST_RUN);

        // Debug reset follows only its own pin, so reset alone spares it
        nxt_st.dbg_sync = {cur_ff.dbg_sync[1:0], DEBUG_RESET_N};
        if (cur_ff.dbg_sync[1] == cur_ff.dbg_sync[2]) begin
            nxt_st.dbg_rst = ~cur_ff.dbg_sync[2]; // [RULE11]
        end

        // Pin input sampling, change taken when stages 2 and 3 agree
        nxt_st.pin_s1 = MUX_PIN_IN;
        nxt_st.pin_s2 = cur_ff.pin_s1;
        nxt_st.pin_s3 = cur_ff.pin_s2;
        for (int i = 0; i < 3; i++) begin
            if (cur_ff.pin_s2[i] == cur_ff.pin_s3[i]) begin
                nxt_st.pin_val[i] = cur_ff.pin_s3[i];
            end
        end

        // Interrupt request pin, same filter as the mux pins
        nxt_st.irq_sync = {cur_ff.irq_sync[1:0],
            EXTERNAL_INTERRUPT_REQUEST_N}; // [RULE6]
        if (cur_ff.irq_sync[1] == cur_ff.irq_sync[2]) begin
            nxt_st.irq_prev = cur_ff.irq_sync[2];
        end
        // Level mode requests while low, edge mode on a fall
        if (cur_ff.irq_edge) begin
            nxt_st.service = cur_ff.irq_prev & ~nxt_st.irq_prev; // [RULE7]
        end else begin
            nxt_st.service = ~nxt_st.irq_prev; // [RULE7]
        end
        // Wake skips the filter: the clock may be stopped then
        nxt_st.wake = STOP_OR_WAIT & ~EXTERNAL_INTERRUPT_REQUEST_N; // [RULE5]
        stat_ev_irq = nxt_st.service;
        stat_ev_rst = (cur_ff.rst_st == pin_mux_pkg::RST_COUNT) &&
            (nxt_st.rst_st == pin_mux_pkg::RST_RUN);

        // APB, answer one edge after the access phase starts
        nxt_st.pready = acc;
        nxt_st.pslverr = 1'b0;
        nxt_st.prdata = '0;
        if (acc) begin
            unique case (PADDR)
                `PM_FUNC_OFS: begin
                    nxt_st.prdata = {26'h0, cur_ff.func};
                    if (wr) begin
                        nxt_st.func = PWDATA[5:0];
                    end
                end
                `PM_DIR_OFS: begin
                    nxt_st.prdata = {29'h0, cur_ff.dir};
                    if (wr) begin
                        nxt_st.dir = PWDATA[2:0]; // [RULE4]
                    end
                end
                `PM_OUT_OFS: begin
                    nxt_st.prdata = {29'h0, cur_ff.pout};
                    if (wr) begin
                        nxt_st.pout = PWDATA[2:0];
                    end
                end
                `PM_IN_OFS: begin
                    nxt_st.prdata = {29'h0, cur_ff.pin_val};
                end
                `PM_IRQCFG_OFS: begin
                    nxt_st.prdata = {31'h0, cur_ff.irq_edge};
                    if (wr) begin
                        nxt_st.irq_edge = PWDATA[`PM_IRQ_EDGE_BIT];
                    end
                end
                `PM_STAT_OFS: begin
                    nxt_st.prdata = {30'h0, cur_ff.stat};
                    if (wr) begin
                        nxt_st.stat = cur_ff.stat & ~PWDATA[1:0];
                    end
                end
                `PM_MASK_OFS: begin
                    nxt_st.prdata = {30'h0, cur_ff.mask};
                    if (wr) begin
                        nxt_st.mask = PWDATA[1:0];
                    end
                end
                `PM_RSTSTAT_OFS: begin
                    nxt_st.prdata = {31'h0, cur_ff.dbg_rst};
                end
                default: begin
                    // Unmapped word: error, write dropped, read zero
                    nxt_st.pslverr = 1'b1;
                end
            endcase
        end

        // Set beats clear in the same cycle
        if (stat_ev_irq) begin
            nxt_st.stat[`PM_STAT_IRQ_BIT] = 1'b1;
        end
        if (stat_ev_rst) begin
            nxt_st.stat[`PM_STAT_RSTDONE_BIT] = 1'b1;
        end
        nxt_st.irq = |(nxt_st.stat & nxt_st.mask);

        // Pin routing per function, timer by default
        tmr_v = {TIMER_C_CHANNEL3_OUT, TIMER_C_CHANNEL1_OUT,
            TIMER_C_CHANNEL0_OUT}; // [RULE1] [RULE2] [RULE3]
        for (int i = 0; i < 3; i++) begin
            f[i] = pin_mux_pkg::pin_func_t'(cur_ff.func[2*i +: 2]);
            out_v[i] = tmr_v[i];
            drv_v[i] = TIMER_C_DRIVE[i];
            nxt_st.tin[i] = 1'b0;
            unique case (f[i])
                pin_mux_pkg::FUNC_TIMER: begin
                    nxt_st.tin[i] = cur_ff.pin_val[i];
                end
                pin_mux_pkg::FUNC_SERIAL: begin
                    // Serial only on pins 0 and 1; pin 2 stays timer
                    if (i == 0) begin
                        out_v[i] = SERIAL0_TRANSMIT_OUT; // [RULE1]
                        drv_v[i] = 1'b1;
                    end else if (i == 1) begin
                        drv_v[i] = 1'b0; // [RULE2]
                    end else begin
                        nxt_st.tin[i] = cur_ff.pin_val[i]; // [RULE3]
                    end
                end
                pin_mux_pkg::FUNC_PORT: begin
                    out_v[i] = cur_ff.pout[i];
                    drv_v[i] = cur_ff.dir[i]; // [RULE4]
                end
                default: begin
                    // Unused code keeps the pin on its timer
                    nxt_st.tin[i] = cur_ff.pin_val[i];
                end
            endcase
        end
        nxt_st.rxd = 1'b1;
        if (f[1] == pin_mux_pkg::FUNC_SERIAL) begin
            nxt_st.rxd = cur_ff.pin_val[1]; // [RULE2]
        end
        nxt_st.mout = out_v;
        nxt_st.moe_n = ~drv_v;
        // Pull-up dropped only on a driven pin
        nxt_st.pull = {2'b11, ~drv_v};

        // Core reset: config back to timers, every pin an input
        if (cur_ff.core_rst) begin
            nxt_st.func = `PM_FUNC_RST; // [RULE1] [RULE2] [RULE3]
            nxt_st.dir = '0;
            nxt_st.pout = '0;
            nxt_st.irq_edge = 1'b0;
            nxt_st.moe_n = 3'h7; // [RULE13]
            nxt_st.mout = '0;
            nxt_st.pull = 5'h1f; // [RULE13]
            nxt_st.service = 1'b0;
            nxt_st.tin = '0;
            nxt_st.rxd = 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            // Bus reset puts every pin back to input with pull-up
            cur_ff.func <= `PM_FUNC_RST;
            cur_ff.dir <= 3'h0;
            cur_ff.pout <= 3'h0;
            cur_ff.irq_edge <= 1'b0;
            cur_ff.stat <= 2'h0;
            cur_ff.mask <= 2'h0;
            cur_ff.irq_sync <= 3'h7;
            cur_ff.irq_prev <= 1'b1;
            cur_ff.rst_sync <= 2'h0;
            cur_ff.rst_st <= pin_mux_pkg::RST_HOLD;
            cur_ff.rst_cnt <= '0;
            // Idle pins read high, so no false change after reset
            cur_ff.pin_s1 <= 3'h7;
            cur_ff.pin_s2 <= 3'h7;
            cur_ff.pin_s3 <= 3'h7;
            cur_ff.pin_val <= 3'h7;
            cur_ff.dbg_sync <= 3'h0;
            cur_ff.prdata <= 32'h0;
            cur_ff.pready <= 1'b0;
            cur_ff.pslverr <= 1'b0;
            cur_ff.mout <= 3'h0;
            cur_ff.moe_n <= 3'h7;
            cur_ff.pull <= 5'h1f;
            cur_ff.tin <= 3'h0;
            cur_ff.rxd <= 1'b1;
            cur_ff.service <= 1'b0;
            cur_ff.wake <= 1'b0;
            cur_ff.irq <= 1'b0;
            cur_ff.core_rst <= 1'b1;
            cur_ff.dbg_rst <= 1'b1;
        end else begin
            cur_ff <= nxt_st;
        end
    end

    // Every output straight from the state register
    assign PRDATA = cur_ff.prdata;
    assign PREADY = cur_ff.pready;
    assign PSLVERR = cur_ff.pslverr;
    assign MUX_PIN_OUT = cur_ff.mout;
    assign MUX_PIN_OE_N = cur_ff.moe_n;
    assign PIN_PULLUP_EN = cur_ff.pull;
    assign TIMER_C_IN = cur_ff.tin;
    assign SERIAL0_RECEIVE_IN = cur_ff.rxd;
    assign IRQ_SERVICE = cur_ff.service;
    assign IRQ_WAKE = cur_ff.wake;
    assign IRQ = cur_ff.irq;
    assign CORE_RESET = cur_ff.core_rst;
    assign DEBUG_RESET = cur_ff.dbg_rst;
endmodule

// File: core/pin_mux_consts.svh
// Offsets, field positions, reset values and counts for the pin mux block
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH
`define PM_ADDR_W 12
`define PM_FUNC_OFS 12'h000
`define PM_DIR_OFS 12'h004
`define PM_OUT_OFS 12'h008
`define PM_IN_OFS 12'h00c
`define PM_IRQCFG_OFS 12'h010
`define PM_STAT_OFS 12'h014
`define PM_MASK_OFS 12'h018
`define PM_RSTSTAT_OFS 12'h01c
`define PM_FUNC_RST 6'h00
`define PM_IRQ_EDGE_BIT 0
`define PM_STAT_IRQ_BIT 0
`define PM_STAT_RSTDONE_BIT 1
`define PM_RST_RELEASE_CYC 16
`endif

// File: core/pin_mux_pkg.sv
// Types for the pin mux block
package pin_mux_pkg;
    typedef enum logic [1:0] {
        FUNC_TIMER = 2'h0,
        FUNC_SERIAL = 2'h1,
        FUNC_PORT = 2'h2
    } pin_func_t;
    typedef enum logic [2:0] {
        RST_HOLD = 3'b001,
        RST_COUNT = 3'b010,
        RST_RUN = 3'b100
    } rst_state_t;
endpackage

// File: dv/pin_mux_properties.sv
// Port assertions for the pin mux block
`timescale 1ns/10ps
module pin_mux_properties (
    // Clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // Watched ports
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [2:0] MUX_PIN_OE_N,
    input wire logic [4:0] PIN_PULLUP_EN,
    input wire logic EXTERNAL_INTERRUPT_REQUEST_N,
    input wire logic STOP_OR_WAIT,
    input wire logic IRQ_SERVICE,
    input wire logic IRQ_WAKE,
    input wire logic HW_RESET_N,
    input wire logic DEBUG_RESET_N,
    input wire logic CORE_RESET,
    input wire logic DEBUG_RESET
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    sequence s_access;
        PSEL && PENABLE && !PREADY;
    endsequence
    sequence s_release;
        $rose(HW_RESET_N);
    endsequence
    a_ready_one_wait: assert property (s_access |=> PREADY)
        else $error("ready late");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready too long");
    a_err_with_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    a_reset_pins_in: assert property (
        CORE_RESET [*2] |-> MUX_PIN_OE_N == 3'h7) else $error("pin driven");
    a_reset_pullups: assert property (
        CORE_RESET [*2] |-> PIN_PULLUP_EN == 5'h1f) else $error("pull off");
    a_hw_hold: assert property (!HW_RESET_N [*4] |-> CORE_RESET)
        else $error("core not in reset");
    a_release_sync: assert property (s_release |-> CORE_RESET [*3])
        else $error("release too early");
    a_debug_spared: assert property (
        DEBUG_RESET_N [*5] |-> !DEBUG_RESET) else $error("debug reset");
    a_wake_async: assert property (
        STOP_OR_WAIT && !EXTERNAL_INTERRUPT_REQUEST_N |=> IRQ_WAKE)
        else $error("no wake");
    a_service_sync: assert property (
        $rose(IRQ_SERVICE) |-> !$past(EXTERNAL_INTERRUPT_REQUEST_N, 2))
        else $error("request not synchronised");
endmodule

// File: dv/pin_board_model.sv
// Board model: pin drivers, interrupt request and reset lines
`timescale 1ns/10ps
module pin_board_model (
    // Device side
    input wire logic clk,
    input wire logic [2:0] oe_n,
    input wire logic [2:0] dout,
    input wire logic [2:0] pull,
    // Board lines
    output logic [2:0] pin,
    output logic irq_n = 1'b1,
    output logic hw_rst_n = 1'b1,
    output logic dbg_rst_n = 1'b1
);
    logic [2:0] drv = 3'h0;
    logic [2:0] val = 3'h0;
    // Released pin not driven by the board rests at its pull-up, never a stale level
    always_comb pin = ~oe_n & dout | oe_n & (drv & val | ~drv & pull);
    // Debug reset only with a full reset
    task pulse_reset(input logic full, input int n);
        hw_rst_n <= 1'b0;
        dbg_rst_n <= ~full;
        repeat (n) @(posedge clk);
        hw_rst_n <= 1'b1;
        dbg_rst_n <= 1'b1;
    endtask
endmodule

// File: dv/timer_pin_mux_reset_irq_inputs_tb.sv
// Self-checking bench for the pin mux block
`timescale 1ns/10ps
`include "pin_mux_consts.svh"
module timer_pin_mux_reset_irq_inputs_tb;
    localparam int REL = 2;
    logic clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, sw = 0, tx = 1;
    logic ch0 = 0, pready, pslverr, err, svc, wake, irq, crst, drst, rx;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0] tdrv = 3'h0, pin, pout, oe_n, tin;
    logic [4:0] pull;
    int fail_count = 0, cmp_count = 0, n;
    timer_pin_mux_reset_irq_inputs #(.RST_RELEASE_CYC(REL)) uut (
        .CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .MUX_PIN_IN(pin), .MUX_PIN_OUT(pout),
        .MUX_PIN_OE_N(oe_n), .PIN_PULLUP_EN(pull),
        .TIMER_C_CHANNEL0_OUT(ch0), .TIMER_C_CHANNEL1_OUT(1'b0),
        .TIMER_C_CHANNEL3_OUT(1'b0), .TIMER_C_DRIVE(tdrv), .TIMER_C_IN(tin),
        .SERIAL0_TRANSMIT_OUT(tx), .SERIAL0_RECEIVE_IN(rx),
        .EXTERNAL_INTERRUPT_REQUEST_N(board.irq_n), .STOP_OR_WAIT(sw),
        .IRQ_SERVICE(svc), .IRQ_WAKE(wake), .IRQ(irq),
        .HW_RESET_N(board.hw_rst_n), .DEBUG_RESET_N(board.dbg_rst_n),
        .CORE_RESET(crst), .DEBUG_RESET(drst));
    pin_board_model board (.clk(clk), .oe_n(oe_n), .dout(pout),
        .pull(pull[2:0]), .pin(pin), .irq_n(), .hw_rst_n(), .dbg_rst_n());
    initial forever #2 clk = ~clk;
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        pen <= 1;
        do begin @(posedge clk); k++; end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 0; pen <= 0;
        @(posedge clk);
    endtask
    task run_wait;
        n = 0;
        while (crst !== 1'b0 && n < 40) begin @(posedge clk); n++; end
    endtask
    task t_timer;
        board.drv <= 3'h7; board.val <= 3'h5;
        repeat (6) @(posedge clk);
        chk(tin, 3'h5);
        apb(0, `PM_FUNC_OFS, 0);
        chk(rd, 0);
        tdrv <= 3'h1; ch0 <= 1; board.drv <= 3'h6;
        repeat (4) @(posedge clk);
        chk({oe_n[0], pout[0]}, 2'b01);
        tdrv <= 3'h0;
    endtask
    task t_port;
        apb(1, `PM_FUNC_OFS, 32'h2a);
        apb(1, `PM_DIR_OFS, 32'h5);
        apb(1, `PM_OUT_OFS, 32'h1);
        board.drv <= 3'h2; board.val <= 3'h0;
        repeat (6) @(posedge clk);
        chk({oe_n, pout[2], pout[0]}, 5'b01001);
        chk(pull, 5'h1a);
        apb(0, `PM_IN_OFS, 0);
        chk(rd, 32'h1);
        apb(1, `PM_FUNC_OFS, 32'h5);
        tx <= 0;
        repeat (6) @(posedge clk);
        chk({oe_n[1:0], pout[0], rx}, 4'b1000);
        tx <= 1; board.drv <= 3'h0;
    endtask
    task t_irq;
        apb(1, `PM_MASK_OFS, 1);
        board.irq_n <= 0;
        repeat (6) @(posedge clk);
        chk({svc, irq}, 2'b11);
        board.irq_n <= 1;
        repeat (6) @(posedge clk);
        apb(1, `PM_STAT_OFS, 32'h3);
        chk(irq, 0);
        apb(1, `PM_IRQCFG_OFS, 1);
        board.irq_n <= 0;
        n = 0;
        repeat (10) begin @(posedge clk); n += svc; end
        chk(n, 1);
        sw <= 1;
        repeat (2) @(posedge clk);
        chk(wake, 1);
        sw <= 0; board.irq_n <= 1;
        apb(1, `PM_MASK_OFS, 0);
        chk(irq, 0);
        apb(0, `PM_STAT_OFS, 0);
        chk(rd[0], 1);
    endtask
    task t_reset;
        apb(1, `PM_FUNC_OFS, 32'h2a);
        fork
            board.pulse_reset(0, 6);
            begin
                repeat (5) @(posedge clk);
                chk({crst, drst}, 2'b10);
            end
        join
        run_wait;
        chk(n inside {[REL + 1:REL + 6]}, 1);
        apb(0, `PM_FUNC_OFS, 0);
        chk(rd, 0);
        apb(0, 12'h020, 0);
        chk({err, rd[7:0]}, 9'h100);
    endtask
    task summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        fork board.pulse_reset(1, 16); join_none
        repeat (16) @(posedge clk);
        srst <= 0;
        run_wait;
        t_timer; t_port; t_irq; t_reset;
        summarize;
    end
    initial begin
        #40000;
        fail_count++;
        summarize;
    end
endmodule
bind timer_pin_mux_reset_irq_inputs pin_mux_properties chk_i (.*);
